// ===== hw/sass_sequencer.sv
// sequencer for the successive-approximation converter
// Contract
// - each result is a 10-bit value stored at full width.
// - the channel selector addresses channels 0 to 31.
// - automatic modes visit only channels 0 to 10; others need single mode.
// - exactly three modes exist: single, round robin and one time.
// - single mode without continuous converts the chosen channel once and then interrupts.
// - after enabling, a programmable enable delay precedes sampling.
// - sampling lasts a programmable window before conversion starts.
// - conversion lasts exactly 12 cycles and then the result is readable.
// - the done interrupt stands 2 cycles with the result already stored.
// - continuous single mode restarts sampling once the interrupt ends.
// - each result stays readable by firmware until overwritten.
// - round robin steps from channel 0 upward storing each channel's result.
// - round robin repeats forever, each result replacing the previous one.
// - one time mode runs the same sequence, stops after the last and interrupts.
module sass_sequencer #(
	parameter int DLY_W = sass_pkg::DLY_W
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             adc_enable,
	input  wire logic [1:0]       mode_sel,
	input  wire logic             continuous,
	input  wire logic [4:0]       chan_sel,
	input  wire logic [DLY_W-1:0] enable_delay,
	input  wire logic [DLY_W-1:0] sample_window,
	input  wire logic [9:0]       conv_result,
	input  wire logic [4:0]       read_chan,
	output logic      [4:0]       mux_chan_ff,
	output logic                  sample_ff,
	output logic                  convert_ff,
	output logic                  done_interrupt_pulse_ff,
	output logic                  seq_busy_ff,
	output logic      [9:0]       last_result_ff,
	output logic      [9:0]       read_data_ff
);
	// counter must hold the conversion count of 12 cycles
	if (DLY_W < 4 || DLY_W > 16) begin : g_dly_chk
		$error("DLY_W out of range");
	end

	sass_pkg::sass_state_e st_ff, nxt_st;
	logic [DLY_W-1:0] cnt_ff, nxt_cnt;
	logic [4:0]       ch_ff, nxt_ch;
	logic             nxt_int_ok;

	wire auto_mode  = (mode_sel == sass_pkg::MODE_ROBIN) || (mode_sel == sass_pkg::MODE_ONCE);
	wire mode_ok    = auto_mode || (mode_sel == sass_pkg::MODE_SINGLE);
	wire last_auto  = (ch_ff == sass_pkg::AUTO_LAST_CH);
	wire [4:0] first_ch = auto_mode ? 5'h00 : chan_sel;
	wire [4:0] step_ch  = last_auto ? 5'h00 : ch_ff + 5'h01;
	wire conv_done  = (st_ff == sass_sdone_st());
	// abandoned conversions leave both result copies untouched
	wire wr_result  = conv_done && (cnt_ff == '0) && adc_enable && mode_ok;

	function automatic sass_pkg::sass_state_e sass_sdone_st();
		return sass_pkg::SASS_CONV;
	endfunction : sass_sdone_st

	always_comb begin
		nxt_st     = st_ff;
		nxt_cnt    = cnt_ff;
		nxt_ch     = ch_ff;
		nxt_int_ok = 1'b0;
		if (!adc_enable || !mode_ok) begin
			nxt_st  = sass_pkg::SASS_IDLE;
			nxt_cnt = '0;
		end else begin
			case (st_ff)
				sass_pkg::SASS_IDLE: begin
					nxt_st  = sass_pkg::SASS_ENDLY;
					nxt_cnt = enable_delay;
					nxt_ch  = first_ch;
				end
				sass_pkg::SASS_ENDLY: begin
					if (cnt_ff == '0) begin
						nxt_st  = sass_pkg::SASS_SAMPLE;
						nxt_cnt = sample_window;
						nxt_ch  = first_ch;
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				sass_pkg::SASS_SAMPLE: begin
					if (cnt_ff == '0) begin
						nxt_st  = sass_pkg::SASS_CONV;
						nxt_cnt = DLY_W'(sass_pkg::CONV_CYC - 1);
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				sass_pkg::SASS_CONV: begin
					if (cnt_ff == '0) begin
						if (mode_sel == sass_pkg::MODE_ROBIN) begin
							nxt_st  = sass_pkg::SASS_SAMPLE;
							nxt_cnt = sample_window;
							nxt_ch  = step_ch;
						end else if (mode_sel == sass_pkg::MODE_ONCE && !last_auto) begin
							nxt_st  = sass_pkg::SASS_SAMPLE;
							nxt_cnt = sample_window;
							nxt_ch  = step_ch;
						end else begin
							nxt_st     = sass_pkg::SASS_INT;
							nxt_cnt    = DLY_W'(sass_pkg::INT_CYC - 1);
							nxt_int_ok = 1'b1;
						end
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				sass_pkg::SASS_INT: begin
					nxt_int_ok = 1'b1;
					if (cnt_ff == '0) begin
						nxt_int_ok = 1'b0;
						if (mode_sel == sass_pkg::MODE_SINGLE && continuous) begin
							nxt_st  = sass_pkg::SASS_SAMPLE;
							nxt_cnt = sample_window;
							nxt_ch  = chan_sel;
						end else begin
							nxt_st = sass_pkg::SASS_HALT;
						end
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
				default: begin
					nxt_st = sass_pkg::SASS_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_ff     <= sass_pkg::SASS_IDLE;
			cnt_ff    <= '0;
			ch_ff     <= 5'h00;
		end else begin
			st_ff     <= nxt_st;
			cnt_ff    <= nxt_cnt;
			ch_ff     <= nxt_ch;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mux_chan_ff             <= 5'h00;
			sample_ff               <= 1'b0;
			convert_ff              <= 1'b0;
			done_interrupt_pulse_ff <= 1'b0;
			seq_busy_ff             <= 1'b0;
			last_result_ff          <= sass_pkg::RES_RST;
		end else begin
			mux_chan_ff             <= nxt_ch;
			sample_ff               <= (nxt_st == sass_pkg::SASS_SAMPLE);
			convert_ff              <= (nxt_st == sass_pkg::SASS_CONV);
			done_interrupt_pulse_ff <= nxt_int_ok;
			seq_busy_ff             <= (nxt_st != sass_pkg::SASS_IDLE) && (nxt_st != sass_pkg::SASS_HALT);
			if (wr_result) begin
				last_result_ff <= conv_result;
			end
		end
	end

	sass_result_store #(
		.W  (sass_pkg::RES_W),
		.N  (sass_pkg::NUM_CH),
		.AW (sass_pkg::CH_W)
	) u_store (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.wr_en      (wr_result),
		.wr_ch      (ch_ff),
		.wr_data    (conv_result),
		.rd_ch      (read_chan),
		.rd_data_ff (read_data_ff)
	);

	sequence conv_run_s;
		convert_ff [*8];
	endsequence

	conv_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(convert_ff) |-> conv_run_s ##1 convert_ff[*4] ##1 !convert_ff)
		else $error("conversion phase not 12 cycles");
	int_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(done_interrupt_pulse_ff) |=> done_interrupt_pulse_ff ##1 !done_interrupt_pulse_ff)
		else $error("interrupt pulse not 2 cycles");
	int_after_conv_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(done_interrupt_pulse_ff) |-> $past(convert_ff))
		else $error("interrupt without conversion");
	int_result_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(done_interrupt_pulse_ff) |-> last_result_ff == $past(conv_result))
		else $error("result not ready with interrupt");
	disable_abort_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!adc_enable |=> !done_interrupt_pulse_ff && !sample_ff && !convert_ff)
		else $error("activity after disable");
	auto_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(sample_ff && auto_mode) |-> mux_chan_ff <= sass_pkg::AUTO_LAST_CH)
		else $error("auto channel beyond 10");
	robin_no_int_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(mode_sel == sass_pkg::MODE_ROBIN && $past(mode_sel) == sass_pkg::MODE_ROBIN && $past(adc_enable))
		|-> !$rose(done_interrupt_pulse_ff))
		else $error("round robin raised interrupt");
	cont_restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
		($fell(done_interrupt_pulse_ff) && adc_enable && $past(adc_enable) && $past(continuous)
		 && mode_sel == sass_pkg::MODE_SINGLE && $past(mode_sel) == sass_pkg::MODE_SINGLE) |-> sample_ff)
		else $error("continuous mode did not restart");
	enable_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(adc_enable) |=> !sample_ff)
		else $error("sampling without enable delay");
endmodule : sass_sequencer

// ===== hw/sass_pkg.sv
// constants for the converter sense sequencer
package sass_pkg;
	localparam int          RES_W        = 10;
	localparam int          CH_W         = 5;
	localparam int          NUM_CH       = 32;
	localparam logic [4:0]  AUTO_LAST_CH = 5'h0A;
	localparam int          CONV_CYC     = 12;
	localparam int          INT_CYC      = 2;
	localparam int          DLY_W        = 8;
	localparam logic [1:0]  MODE_SINGLE  = 2'h0;
	localparam logic [1:0]  MODE_ROBIN   = 2'h1;
	localparam logic [1:0]  MODE_ONCE    = 2'h2;
	localparam logic [9:0]  RES_RST      = 10'h000;
	typedef enum logic [2:0] {
		SASS_IDLE   = 3'h0,
		SASS_ENDLY  = 3'h1,
		SASS_SAMPLE = 3'h3,
		SASS_CONV   = 3'h2,
		SASS_INT    = 3'h6,
		SASS_HALT   = 3'h7
	} sass_state_e;
endpackage : sass_pkg

// ===== hw/sass_result_store.sv
// per-channel result storage with a registered read port
module sass_result_store #(
	parameter int W  = 10,
	parameter int N  = 32,
	parameter int AW = 5
) (
	input  wire logic          mclk,
	input  wire logic          rst_b,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_ch,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_ch,
	output logic      [W-1:0]  rd_data_ff
);
	if (N > (1 << AW)) begin : g_depth_chk
		$error("store depth exceeds address range");
	end

	logic [W-1:0] mem_ff [N];

	// results survive until overwritten by the same channel
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_ff[wr_ch] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd_data_ff <= W'(0);
		end else begin
			rd_data_ff <= mem_ff[rd_ch];
		end
	end
endmodule : sass_result_store

// ===== test/sass_adc_model.sv
// converter and input multiplexer seen from the sequencer
module sass_adc_model (
	input  wire logic       mclk,
	input  wire logic       convert,
	input  wire logic [4:0] chan,
	input  wire logic [9:0] salt,
	output logic      [9:0] result
);
	timeunit 1ns;
	timeprecision 1ns;
	initial result = 10'h155;
	// outside a conversion the output keeps changing, never holds
	always @(posedge mclk) begin
		if (convert) begin
			result <= {chan, 5'h00} ^ salt;
		end else begin
			result <= ~result;
		end
	end
endmodule : sass_adc_model

// ===== test/test_sar_adc_sense_sequencer.sv
// self-checking bench for the converter sense sequencer
module test_sar_adc_sense_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0, rst_b = 1'b0, adc_enable = 1'b0, continuous = 1'b0;
	logic [1:0]  mode_sel = 2'h0;
	logic [4:0]  chan_sel = 5'h00, read_chan = 5'h00, mux_chan_ff, ch;
	logic [7:0]  enable_delay = 8'h00, sample_window = 8'h00;
	logic [9:0]  conv_result, salt = 10'h000, last_result_ff, read_data_ff;
	logic        sample_ff, convert_ff, done_interrupt_pulse_ff, seq_busy_ff;
	logic [9:0]  exp_store [32];
	bit          seen [32];
	logic [31:0] rnd = 32'h1CF963AD;
	int          fail_count = 0, n_tests = 0, n;
	sass_sequencer dut_u (.mclk, .rst_b, .adc_enable, .mode_sel, .continuous, .chan_sel, .enable_delay,
		.sample_window, .conv_result, .read_chan, .mux_chan_ff, .sample_ff, .convert_ff,
		.done_interrupt_pulse_ff, .seq_busy_ff, .last_result_ff, .read_data_ff);
	sass_adc_model adc_u (.mclk, .convert(convert_ff), .chan(mux_chan_ff), .salt, .result(conv_result));
	always #10 mclk = ~mclk;
	function automatic logic [31:0] rnd_next();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : rnd_next
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (e !== s) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	task automatic span(input int i, output int k);
		for (k = 0; k < 700 && (i == 0 ? sample_ff : i == 1 ? convert_ff : done_interrupt_pulse_ff) === 1'b1; k++) begin
			@(negedge mclk);
		end
	endtask : span
	task automatic go(input logic [1:0] m, input logic c, input logic [4:0] cs, input logic [7:0] d, w, output int k);
		mode_sel = m;
		continuous = c;
		chan_sel = cs;
		enable_delay = d;
		sample_window = w;
		adc_enable = 1'b1;
		for (k = 0; k < 700 && sample_ff !== 1'b1; k++) begin
			@(negedge mclk);
		end
	endtask : go
	task automatic conv_once(input logic [4:0] c, input int w, input logic irq);
		int k;
		for (k = 0; k < 700 && sample_ff !== 1'b1; k++) begin
			@(negedge mclk);
		end
		chk("mux channel", c, mux_chan_ff);
		salt = 10'(rnd_next());
		exp_store[c] = {c, 5'h00} ^ salt;
		seen[c] = 1'b1;
		span(0, k);
		chk("sample cycles", w + 1, k);
		span(1, k);
		chk("convert cycles", sass_pkg::CONV_CYC, k);
		chk("last result", exp_store[c], last_result_ff);
		chk("interrupt", irq, done_interrupt_pulse_ff);
		span(2, k);
		chk("interrupt cycles", irq ? sass_pkg::INT_CYC : 0, k);
	endtask : conv_once
	task automatic stop();
		adc_enable = 1'b0;
		@(negedge mclk);
	endtask : stop
	initial begin
		repeat (2) @(negedge mclk);
		rst_b = 1'b1;
		for (int i = 0; i < 6; i++) begin
			ch = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'(rnd_next());
			go(sass_pkg::MODE_SINGLE, 1'b0, ch, 8'(i * 3), 8'(i & 3), n);
			chk("enable delay", i * 3 + 2, n);
			conv_once(ch, i & 3, 1'b1);
			repeat (3) @(negedge mclk);
			chk("one shot halted", 2'h0, {seq_busy_ff, sample_ff});
			stop();
		end
		go(sass_pkg::MODE_SINGLE, 1'b1, 5'h0C, 8'h01, 8'h02, n);
		conv_once(5'h0C, 2, 1'b1);
		chk("restart", 1'b1, sample_ff);
		chan_sel = 5'h0D;
		conv_once(5'h0C, 2, 1'b1);
		conv_once(5'h0D, 2, 1'b1);
		for (n = 0; n < 700 && convert_ff !== 1'b1; n++) @(negedge mclk);
		stop();
		repeat (4) begin
			chk("aborted interrupt", 1'b0, done_interrupt_pulse_ff);
			@(negedge mclk);
		end
		chk("aborted busy", 1'b0, seq_busy_ff);
		mode_sel = 2'h3;
		adc_enable = 1'b1;
		repeat (4) @(negedge mclk);
		chk("illegal mode idle", 2'h0, {seq_busy_ff, sample_ff});
		stop();
		go(sass_pkg::MODE_ROBIN, 1'b0, 5'h1F, 8'h00, 8'h00, n);
		for (int i = 0; i < 13; i++) conv_once(5'(i % 11), 0, 1'b0);
		stop();
		go(sass_pkg::MODE_ONCE, 1'b0, 5'h1F, 8'h02, 8'h01, n);
		for (int i = 0; i < 11; i++) conv_once(5'(i), 1, i == 10);
		repeat (3) @(negedge mclk);
		chk("one time halted", 1'b0, seq_busy_ff);
		stop();
		for (int i = 0; i < 32; i++) begin
			read_chan = 5'(i);
			@(negedge mclk);
			if (seen[i]) chk("stored result", exp_store[i], read_data_ff);
		end
		conclude();
	end
	initial begin
		#400000;
		fail_count++;
		conclude();
	end
endmodule : test_sar_adc_sense_sequencer
